// >>> hdl/spi_sec_flash.sv
// Flash slice: three one-time-lockable security registers behind a serial link.
// Assumes link pins are asynchronous to core_clk and sclk is at most core_clk/16.
//
// Our own choices: the Avalon-MM register port and the register addresses.
`include "spi_sec_regs.svh"

// Overview of operation
// - Three 256-byte registers, separately erasable and programmable
// - Erase refused unless write-enable latch set
// - Erase: opcode 44h then 24-bit address
// - Address selects register; low byte is offset
// - Erase only if chip select rises byte-aligned
// - Self-timed erase holds busy until done
// - Status read still answered while busy
// - Erase completion clears write-enable latch
// - Lock bit silently blocks erase
// - Program writes one to 256 bytes
// - Program refused unless write-enable latch set
// - Program: opcode 42h, address, data bytes
// - Chip select held low through program
// - Lock bit silently blocks program
// - Read: opcode 48h, address, eight dummy clocks
// - Sample on rising, drive on falling, MSB first
// - Read offset advances and wraps within register
// - Read streams until chip select rises
// - Read ignored while busy
// - Self-timed program cycle with busy set
module spi_sec_flash #(
	parameter int ERASE_NS = `SEC_ERASE_NS,
	parameter int PROG_NS = `SEC_PROG_NS,
	parameter int CLK_NS = `CORE_CLK_NS
) (
	input wire logic core_clk,
	input wire logic nrst,
	spi_link_if.dev link,
	input wire logic [2:0] otp_lock_bits,
	output logic busy,
	output logic write_enable_latch
);

	localparam int ERASE_CYC = (ERASE_NS + CLK_NS - 1) / CLK_NS;
	localparam int PROG_CYC = (PROG_NS + CLK_NS - 1) / CLK_NS;

	if (ERASE_CYC < `SEC_BYTES || PROG_CYC < `SEC_BYTES) begin : g_chk
		$error("Erase and program cycles must cover one pass over a register.");
	end

	spi_sec_pkg::dev_state_t s;
	spi_sec_pkg::dev_state_t n;

	// Array contents are nonvolatile in spirit and carry no reset.
	logic [7:0] mem [0:3*`SEC_BYTES-1];
	logic [7:0] pbuf [0:`SEC_BYTES-1];
	logic mem_we;
	logic [9:0] mem_idx;
	logic [7:0] mem_wd;
	logic buf_we;
	logic [7:0] buf_idx;
	logic [7:0] buf_wd;
	logic rise;
	logic fall;
	logic [7:0] byte_in;
	logic [1:0] sel;
	logic [7:0] walk;
	logic [31:0] last;

	// Returns 1..3 for a valid security-register address, 0 otherwise.
	function automatic logic [1:0] sec_sel(input logic [23:0] a);
		sec_sel = 2'h0;
		if (a[`SEC_UPPER] == `SEC_UPPER_VAL && a[`SEC_MID] == `SEC_MID_VAL && a[`SEC_SEL] != 4'h0
			&& a[`SEC_SEL] < 4'h4) begin
			sec_sel = a[13:12];
		end
	endfunction : sec_sel

	function automatic logic [9:0] mem_at(input logic [1:0] r, input logic [7:0] off);
		mem_at = {r - 2'h1, off};
	endfunction : mem_at

	function automatic logic [7:0] status_byte(input logic second, input logic b, input logic w,
		input logic [2:0] lb);
		status_byte = 8'h00;
		if (second) begin
			status_byte[`SR2_LOCK] = lb;
		end else begin
			status_byte[`SR_BUSY] = b;
			status_byte[`SR_WRITE_EN] = w;
		end
	endfunction : status_byte

	always_comb begin
		n = s;
		mem_we = 1'b0;
		mem_idx = 10'h000;
		mem_wd = `ERASED_BYTE;
		buf_we = 1'b0;
		buf_idx = s.offset;
		buf_wd = 8'h00;
		n.cs_q1 = link.cs_n;
		n.cs_q2 = s.cs_q1;
		n.cs_q3 = s.cs_q2;
		n.sck_q1 = link.sclk;
		n.sck_q2 = s.sck_q1;
		n.sck_q3 = s.sck_q2;
		n.din_q1 = link.serial_data_in;
		n.din_q2 = s.din_q1;
		rise = s.sck_q2 & ~s.sck_q3;
		fall = ~s.sck_q2 & s.sck_q3;
		byte_in = {s.sh[6:0], s.din_q2};
		sel = sec_sel(s.addr);
		walk = s.tmr[7:0];
		last = (s.job == spi_sec_pkg::job_erase) ? 32'(ERASE_CYC - 1) : 32'(PROG_CYC - 1);

		// ----------------------------------------
		// Self-timed erase and program engine
		// ----------------------------------------
		// The first 256 cycles walk the register once; the rest only keeps busy up.
		if (s.busy) begin
			if (s.tmr < 32'(`SEC_BYTES)) begin
				mem_we = 1'b1;
				mem_idx = mem_at(s.target, walk);
				if (s.job == spi_sec_pkg::job_prog) begin
					mem_wd = mem[mem_at(s.target, walk)] & (s.pend[walk] ? pbuf[walk] : `ERASED_BYTE);
					n.pend[walk] = 1'b0;
				end
			end
			n.tmr = s.tmr + 32'h1;
			if (s.tmr == last) begin
				n.busy = 1'b0;
				n.wen_latch = 1'b0;
				n.job = spi_sec_pkg::job_none;
			end
		end

		// ----------------------------------------
		// Serial front end
		// ----------------------------------------
		if (s.cs_q2) begin
			n.miso_oe_n = 1'b1;
			if (!s.cs_q3) begin
				if (!s.busy && s.bitcnt == 3'h0) begin
					if (s.phase == spi_sec_pkg::ph_end && s.op == `OP_WREN) begin
						n.wen_latch = 1'b1;
					end else if (s.wen_latch && sel != 2'h0 && ((s.phase == spi_sec_pkg::ph_end && s.op == `OP_SEC_ERASE)
						|| (s.phase == spi_sec_pkg::ph_data_in && s.got_data))) begin
						if (otp_lock_bits[sel - 2'h1]) begin
							n.wen_latch = 1'b0;
						end else begin
							n.busy = 1'b1;
							n.tmr = 32'h0;
							n.target = sel;
							n.job = (s.op == `OP_SEC_ERASE) ? spi_sec_pkg::job_erase : spi_sec_pkg::job_prog;
						end
					end
				end
				// Staged bytes of a frame that did not start a program are dropped.
				if (!s.busy && !(n.busy && n.job == spi_sec_pkg::job_prog)) begin
					n.pend = '0;
				end
				n.phase = spi_sec_pkg::ph_op;
				n.bitcnt = 3'h0;
				n.acnt = 2'h0;
				n.got_data = 1'b0;
			end
		end else if (rise) begin
			n.sh = byte_in;
			n.bitcnt = s.bitcnt + 3'h1;
			if (s.bitcnt == 3'h7) begin
				case (s.phase)
					spi_sec_pkg::ph_op: begin
						n.op = byte_in;
						case (byte_in)
							`OP_WREN: n.phase = s.busy ? spi_sec_pkg::ph_ignore : spi_sec_pkg::ph_end;
							`OP_RDSR1, `OP_RDSR2: begin
								n.phase = spi_sec_pkg::ph_stat_out;
								n.stat_sel = byte_in;
								n.out_sh = status_byte(byte_in == `OP_RDSR2, s.busy, s.wen_latch, otp_lock_bits);
							end
							`OP_SEC_ERASE, `OP_SEC_PROG, `OP_SEC_READ: begin
								n.phase = s.busy ? spi_sec_pkg::ph_ignore : spi_sec_pkg::ph_addr;
							end
							default: n.phase = spi_sec_pkg::ph_ignore;
						endcase
					end
					spi_sec_pkg::ph_addr: begin
						n.addr = {s.addr[15:0], byte_in};
						n.acnt = s.acnt + 2'h1;
						if (s.acnt == 2'h2) begin
							n.offset = byte_in;
							case (s.op)
								`OP_SEC_READ: n.phase = spi_sec_pkg::ph_dummy;
								`OP_SEC_PROG: n.phase = spi_sec_pkg::ph_data_in;
								default: n.phase = spi_sec_pkg::ph_end;
							endcase
						end
					end
					spi_sec_pkg::ph_dummy, spi_sec_pkg::ph_data_out: begin
						if (sel != 2'h0) begin
							n.phase = spi_sec_pkg::ph_data_out;
							n.out_sh = mem[mem_at(sel, s.offset)];
							n.offset = s.offset + 8'h01;
						end else begin
							n.phase = spi_sec_pkg::ph_ignore;
						end
					end
					spi_sec_pkg::ph_data_in: begin
						buf_we = 1'b1;
						buf_wd = byte_in;
						n.pend[s.offset] = 1'b1;
						n.offset = s.offset + 8'h01;
						n.got_data = 1'b1;
					end
					spi_sec_pkg::ph_stat_out: begin
						n.out_sh = status_byte(s.stat_sel == `OP_RDSR2, s.busy, s.wen_latch, otp_lock_bits);
					end
					spi_sec_pkg::ph_end: n.phase = spi_sec_pkg::ph_ignore;
					default: n.phase = spi_sec_pkg::ph_ignore;
				endcase
			end
		end else if (fall && (s.phase == spi_sec_pkg::ph_data_out || s.phase == spi_sec_pkg::ph_stat_out)) begin
			n.miso = s.out_sh[7];
			n.out_sh = {s.out_sh[6:0], 1'b0};
			n.miso_oe_n = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			s <= '0;
			s.cs_q1 <= 1'b1;
			s.cs_q2 <= 1'b1;
			s.cs_q3 <= 1'b1;
			s.miso <= 1'b1;
			s.miso_oe_n <= 1'b1;
			s.phase <= spi_sec_pkg::ph_op;
			s.job <= spi_sec_pkg::job_none;
		end else begin
			s <= n;
		end
	end

	always_ff @(posedge core_clk) begin
		if (mem_we) begin
			mem[mem_idx] <= mem_wd;
		end
		if (buf_we) begin
			pbuf[buf_idx] <= buf_wd;
		end
	end

	assign link.miso_out = s.miso;
	assign link.miso_oe_n = s.miso_oe_n;
	assign busy = s.busy;
	assign write_enable_latch = s.wen_latch;

endmodule : spi_sec_flash

// >>> hdl/spi_sec_regs.svh
// Constants for the security-register flash slice and its serial host.
// Assumes inclusion by bare name from the package and both ends.
`ifndef SPI_SEC_REGS_SVH
`define SPI_SEC_REGS_SVH

// ----------------------------------------
// Serial opcodes
// ----------------------------------------
`define OP_WREN 8'h06
`define OP_RDSR1 8'h05
`define OP_RDSR2 8'h35
`define OP_SEC_ERASE 8'h44
`define OP_SEC_PROG 8'h42
`define OP_SEC_READ 8'h48

// ----------------------------------------
// Security-register address map
// ----------------------------------------
`define SEC_BYTES 256
`define SEC_UPPER 23:16
`define SEC_UPPER_VAL 8'h00
`define SEC_SEL 15:12
`define SEC_MID 11:8
`define SEC_MID_VAL 4'h0
`define SEC_OFF 7:0
`define ERASED_BYTE 8'hFF

// ----------------------------------------
// Status bytes
// ----------------------------------------
`define SR_BUSY 0
`define SR_WRITE_EN 1
`define SR2_LOCK 5:3

// ----------------------------------------
// Timing
// ----------------------------------------
`define CORE_CLK_NS 25
`define SEC_ERASE_NS 50000
`define SEC_PROG_NS 20000
`define SCLK_HALF 8
`define SCLK_HALF_MIN 8

// ----------------------------------------
// Host register offsets and fields
// ----------------------------------------
`define HR_CTRL 5'h00
`define HR_ADDR 5'h04
`define HR_DATA 5'h08
`define HR_STAT 5'h0C
`define CTRL_GO 31
`define CTRL_OP 7:0
`define CTRL_CNT 16:8
`define STAT_BUSY 8
`define STAT_BYTE 7:0

`endif

// >>> hdl/spi_sec_pkg.sv
// Types shared by the flash slice and the serial host.
// Assumes spi_sec_regs.svh is on the include path.
`include "spi_sec_regs.svh"

package spi_sec_pkg;

	// ----------------------------------------
	// Flash slice
	// ----------------------------------------
	typedef enum logic [2:0] {ph_op, ph_addr, ph_dummy, ph_data_in, ph_data_out, ph_stat_out, ph_end,
		ph_ignore} dev_phase_t;
	typedef enum logic [1:0] {job_none, job_erase, job_prog} job_t;

	typedef struct packed {
		logic cs_q1, cs_q2, cs_q3;
		logic sck_q1, sck_q2, sck_q3;
		logic din_q1, din_q2;
		dev_phase_t phase;
		logic [2:0] bitcnt;
		logic [7:0] sh;
		logic [7:0] op;
		logic [23:0] addr;
		logic [1:0] acnt;
		logic [7:0] offset;
		logic [7:0] out_sh;
		logic [7:0] stat_sel;
		logic got_data;
		logic [255:0] pend;
		job_t job;
		logic [1:0] target;
		logic [31:0] tmr;
		logic busy;
		logic wen_latch;
		logic miso;
		logic miso_oe_n;
	} dev_state_t;

	// ----------------------------------------
	// Serial host
	// ----------------------------------------
	typedef enum logic [2:0] {h_idle, h_low, h_high, h_tail, h_gap} host_phase_t;

	typedef struct packed {
		logic miso_q1, miso_q2;
		host_phase_t phase;
		logic [7:0] div;
		logic [2:0] bitcnt;
		logic [9:0] idx;
		logic [9:0] total;
		logic [8:0] cnt;
		logic [7:0] op;
		logic [23:0] addr;
		logic [7:0] tx;
		logic [7:0] rx;
		logic [7:0] stat;
		logic [7:0] wptr;
		logic [7:0] rptr;
		logic cs_n, sclk, mosi;
		logic wait_r;
		logic [31:0] rdata;
	} host_state_t;

endpackage : spi_sec_pkg

// >>> hdl/spi_link_if.sv
// Four-wire serial link between the host and the flash slice.
// The data-out line idles high when the slice does not drive it.
interface spi_link_if;
	logic cs_n;
	logic sclk;
	logic serial_data_in;
	logic miso_out;
	logic miso_oe_n;
	logic serial_data_out;

	assign serial_data_out = miso_oe_n ? 1'b1 : miso_out;

	modport host (output cs_n, output sclk, output serial_data_in, input serial_data_out);
	modport dev (input cs_n, input sclk, input serial_data_in, output miso_out, output miso_oe_n);
endinterface : spi_link_if

// >>> hdl/spi_sec_host.sv
// Serial host: runs one flash command per software order, set up over Avalon-MM.
// Assumes software issues write-enable and polls busy itself; one buffer serves both directions.
`include "spi_sec_regs.svh"

module spi_sec_host #(
	parameter int HALF = `SCLK_HALF
) (
	input wire logic core_clk,
	input wire logic nrst,
	spi_link_if.host link,
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest
);

	if (HALF < `SCLK_HALF_MIN || HALF > 255) begin : g_chk
		$error("Serial clock half period must leave room for both synchronisers.");
	end

	spi_sec_pkg::host_state_t s;
	spi_sec_pkg::host_state_t n;
	logic [7:0] hbuf [0:`SEC_BYTES-1];
	logic buf_we;
	logic [7:0] buf_idx;
	logic [7:0] buf_wd;
	logic [7:0] rx_byte;
	logic [9:0] hdr;
	logic [9:0] nxt;

	function automatic logic [9:0] hdr_len(input logic [7:0] op);
		case (op)
			`OP_SEC_ERASE, `OP_SEC_PROG: hdr_len = 10'h004;
			`OP_SEC_READ: hdr_len = 10'h005;
			default: hdr_len = 10'h001;
		endcase
	endfunction : hdr_len

	// Data bytes follow program, read and status orders only.
	function automatic logic has_data(input logic [7:0] op);
		has_data = op == `OP_SEC_PROG || op == `OP_SEC_READ || op == `OP_RDSR1 || op == `OP_RDSR2;
	endfunction : has_data

	always_comb begin
		n = s;
		buf_we = 1'b0;
		buf_idx = s.wptr;
		buf_wd = writedata[7:0];
		n.miso_q1 = link.serial_data_out;
		n.miso_q2 = s.miso_q1;
		rx_byte = {s.rx[6:0], s.miso_q2};
		hdr = hdr_len(s.op);
		nxt = s.idx + 10'h001;

		// ----------------------------------------
		// Register slave
		// ----------------------------------------
		if ((read || write) && s.wait_r) begin
			n.wait_r = 1'b0;
			case (address)
				`HR_CTRL: n.rdata = {15'h0000, s.cnt, s.op};
				`HR_ADDR: n.rdata = {8'h00, s.addr};
				`HR_DATA: n.rdata = {24'h000000, hbuf[s.rptr]};
				`HR_STAT: n.rdata = {23'h000000, s.phase != spi_sec_pkg::h_idle, s.stat};
				default: n.rdata = 32'h00000000;
			endcase
		end else if (!s.wait_r) begin
			n.wait_r = 1'b1;
			if (read && address == `HR_DATA) begin
				n.rptr = s.rptr + 8'h01;
			end
			// Setup writes are ignored while a command is on the wire.
			if (write && s.phase == spi_sec_pkg::h_idle) begin
				case (address)
					`HR_CTRL: begin
						n.op = writedata[`CTRL_OP];
						n.cnt = writedata[`CTRL_CNT];
						if (writedata[`CTRL_GO]) begin
							n.phase = spi_sec_pkg::h_low;
							n.cs_n = 1'b0;
							n.div = 8'h00;
							n.bitcnt = 3'h0;
							n.idx = 10'h000;
							n.tx = writedata[`CTRL_OP];
							n.mosi = writedata[7];
							n.total = hdr_len(writedata[`CTRL_OP])
								+ (has_data(writedata[`CTRL_OP]) ? {1'b0, writedata[`CTRL_CNT]} : 10'h000);
							n.wptr = 8'h00;
							n.rptr = 8'h00;
						end
					end
					`HR_ADDR: n.addr = writedata[23:0];
					`HR_DATA: begin
						buf_we = 1'b1;
						n.wptr = s.wptr + 8'h01;
					end
					default: n.op = s.op;
				endcase
			end
		end

		// ----------------------------------------
		// Serial engine
		// ----------------------------------------
		n.div = s.div + 8'h01;
		case (s.phase)
			spi_sec_pkg::h_idle: n.div = 8'h00;
			spi_sec_pkg::h_low: begin
				if (s.div == 8'(HALF - 1)) begin
					n.div = 8'h00;
					n.sclk = 1'b1;
					n.rx = rx_byte;
					n.phase = spi_sec_pkg::h_high;
				end
			end
			spi_sec_pkg::h_high: begin
				if (s.div == 8'(HALF - 1)) begin
					n.div = 8'h00;
					n.sclk = 1'b0;
					n.bitcnt = s.bitcnt + 3'h1;
					n.tx = {s.tx[6:0], 1'b0};
					n.mosi = s.tx[6];
					n.phase = spi_sec_pkg::h_low;
					if (s.bitcnt == 3'h7) begin
						if (s.idx >= hdr && s.op != `OP_SEC_PROG) begin
							buf_we = 1'b1;
							buf_idx = 8'(s.idx - hdr);
							buf_wd = s.rx;
							n.stat = s.rx;
						end
						n.idx = nxt;
						// Chip select stays low over every byte of the order.
						if (nxt == s.total) begin
							n.phase = spi_sec_pkg::h_tail;
						end else begin
							case (nxt)
								10'h001: n.tx = (hdr == 10'h001) ? hbuf[8'h00] : s.addr[`SEC_UPPER];
								10'h002: n.tx = (hdr == 10'h001) ? hbuf[8'h01] : s.addr[15:8];
								10'h003: n.tx = (hdr == 10'h001) ? hbuf[8'h02] : s.addr[`SEC_OFF];
								default: n.tx = (nxt < hdr) ? 8'h00 : hbuf[8'(nxt - hdr)];
							endcase
							n.mosi = n.tx[7];
						end
					end
				end
			end
			spi_sec_pkg::h_tail: begin
				if (s.div == 8'(HALF - 1)) begin
					n.div = 8'h00;
					n.cs_n = 1'b1;
					n.phase = spi_sec_pkg::h_gap;
				end
			end
			spi_sec_pkg::h_gap: begin
				if (s.div == 8'(HALF - 1)) begin
					n.phase = spi_sec_pkg::h_idle;
				end
			end
			default: n.phase = spi_sec_pkg::h_idle;
		endcase
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			s <= '0;
			s.miso_q1 <= 1'b1;
			s.miso_q2 <= 1'b1;
			s.cs_n <= 1'b1;
			s.wait_r <= 1'b1;
			s.phase <= spi_sec_pkg::h_idle;
		end else begin
			s <= n;
		end
	end

	always_ff @(posedge core_clk) begin
		if (buf_we) begin
			hbuf[buf_idx] <= buf_wd;
		end
	end

	assign link.cs_n = s.cs_n;
	assign link.sclk = s.sclk;
	assign link.serial_data_in = s.mosi;
	assign readdata = s.rdata;
	assign waitrequest = s.wait_r;

endmodule : spi_sec_host

// >>> verification/spi_sec_chk.sv
// Concurrent checks on the serial link between the host and the flash slice.
// Assumes the testbench wires the link signals, busy and the write-enable latch here.
module spi_sec_chk (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic serial_data_in,
	input wire logic miso_out,
	input wire logic miso_oe_n,
	input wire logic serial_data_out,
	input wire logic busy,
	input wire logic write_enable_latch
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	// ----------------------------------------
	// Self-timed cycles
	// ----------------------------------------
	end_clears_latch_a: assert property ($fell(busy) |-> ##[0:1] !write_enable_latch)
		else $error("latch still set after cycle");
	start_after_cs_a: assert property ($rose(busy) |-> cs_n && $past(cs_n, 3))
		else $error("cycle began with chip select low");
	start_needs_wel_a: assert property ($rose(busy) |-> write_enable_latch)
		else $error("cycle began without write enable");
	busy_holds_a: assert property ($rose(busy) |=> busy [*8])
		else $error("busy dropped early");

	// ----------------------------------------
	// Wire timing
	// ----------------------------------------
	released_idle_a: assert property (cs_n [*8] |-> miso_oe_n)
		else $error("data out driven while deselected");
	line_idle_high_a: assert property (cs_n [*8] |-> serial_data_out)
		else $error("data out line not high while deselected");
	drive_on_fall_a: assert property (!miso_oe_n && $changed(miso_out) |-> !sclk)
		else $error("data out moved while clock high");
	idle_clock_low_a: assert property (cs_n |-> !sclk)
		else $error("clock high while deselected");
	sample_stable_a: assert property (sclk |-> $stable(serial_data_in))
		else $error("data in moved while clock high");
endmodule : spi_sec_chk

// >>> verification/testbench.sv
// Self-checking bench: host and flash slice joined by the link, driven over Avalon-MM.
// Assumes the design files and spi_sec_regs.svh are on the include path.
`include "spi_sec_regs.svh"

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic nrst, read, write, waitrequest, busy, write_enable_latch;
	logic [4:0] address;
	logic [31:0] writedata, readdata, r;
	logic [2:0] otp_lock_bits;
	logic [7:0] d0 [1:3];
	logic [7:0] d1 [1:3];
	logic [3:0] i;
	integer seed, failures, checked;

	always #12.5 core_clk = ~core_clk;

	spi_link_if link ();
	spi_sec_host u_spi_sec_host (.core_clk(core_clk), .nrst(nrst), .link(link), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
	// Erase is kept long enough that a one-byte read fits inside it.
	spi_sec_flash #(.ERASE_NS(30000), .PROG_NS(7000)) u_spi_sec_flash (.core_clk(core_clk), .nrst(nrst),
		.link(link), .otp_lock_bits(otp_lock_bits), .busy(busy), .write_enable_latch(write_enable_latch));
	spi_sec_chk u_spi_sec_chk (.core_clk(core_clk), .nrst(nrst), .cs_n(link.cs_n), .sclk(link.sclk),
		.serial_data_in(link.serial_data_in), .miso_out(link.miso_out), .miso_oe_n(link.miso_oe_n),
		.serial_data_out(link.serial_data_out), .busy(busy), .write_enable_latch(write_enable_latch));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task conclude;
		if (failures == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude

	task chk(input logic [7:0] got, input logic [7:0] exp);
		checked = checked + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [23:0] sa(input logic [3:0] rg, input logic [7:0] off);
		return {8'h00, rg, 4'h0, off};
	endfunction : sa

	// The request stands until waitrequest is seen low at a rising edge; read data is taken at that edge.
	task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		integer n;
		@(posedge core_clk);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		n = 0;
		@(posedge core_clk);
		while (waitrequest !== 1'b0) begin
			n = n + 1;
			if (n > 100) begin
				failures = failures + 1;
				conclude();
			end
			@(posedge core_clk);
		end
		r = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus

	task cmd(input logic [7:0] op, input logic [23:0] a, input logic [8:0] cnt);
		integer n;
		bus(1'b1, `HR_ADDR, {8'h00, a});
		bus(1'b1, `HR_CTRL, {1'b1, 14'h0000, cnt, op});
		n = 0;
		r = 32'h00000100;
		while (r[`STAT_BUSY] !== 1'b0) begin
			n = n + 1;
			if (n > 2000) begin
				failures = failures + 1;
				conclude();
			end
			bus(1'b0, `HR_STAT, 32'h00000000);
		end
	endtask : cmd

	task settle;
		integer n;
		n = 0;
		@(negedge core_clk);
		while (busy !== 1'b0) begin
			n = n + 1;
			if (n > 5000) begin
				failures = failures + 1;
				conclude();
			end
			@(negedge core_clk);
		end
	endtask : settle

	task wren;
		cmd(`OP_WREN, 24'h000000, 9'h001);
	endtask : wren

	task prog(input logic [3:0] rg, input logic [7:0] off, input logic [7:0] b, input logic runs);
		wren();
		bus(1'b1, `HR_DATA, {24'h000000, b});
		cmd(`OP_SEC_PROG, sa(rg, off), 9'h001);
		chk({7'h00, busy}, {7'h00, runs});
		settle();
		chk({7'h00, write_enable_latch}, 8'h00);
	endtask : prog

	task rdchk(input logic [3:0] rg, input logic [7:0] off, input logic [23:0] e);
		cmd(`OP_SEC_READ, sa(rg, off), 9'h003);
		for (int k = 0; k < 3; k++) begin
			bus(1'b0, `HR_DATA, 32'h00000000);
			chk(r[7:0], e[23 - 8 * k -: 8]);
		end
	endtask : rdchk

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		seed = 32'hf6fc1121;
		failures = 0;
		checked = 0;
		nrst = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = 5'h00;
		writedata = 32'h00000000;
		otp_lock_bits = 3'h0;
		repeat (8) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (4) @(posedge core_clk);
		cmd(`OP_SEC_ERASE, sa(4'h1, 8'h00), 9'h001);
		repeat (10) @(negedge core_clk);
		chk({7'h00, busy}, 8'h00);
		for (i = 4'h1; i <= 4'h3; i++) begin
			wren();
			cmd(`OP_SEC_ERASE, sa(i, 8'($random(seed))), 9'h001);
			cmd(`OP_RDSR1, 24'h000000, 9'h001);
			chk(r[7:0] & 8'h03, 8'h03);
			settle();
			chk({7'h00, write_enable_latch}, 8'h00);
			d0[i] = 8'($random(seed));
			d1[i] = 8'($random(seed)) & 8'hFE;
			prog(i, 8'hFF, d1[i], 1'b1);
			prog(i, 8'h00, d0[i], 1'b1);
		end
		for (i = 4'h1; i <= 4'h3; i++)
			rdchk(i, 8'hFE, {8'hFF, d1[i], d0[i]});
		@(posedge core_clk);
		otp_lock_bits <= 3'b010;
		wren();
		cmd(`OP_SEC_ERASE, sa(4'h2, 8'h00), 9'h001);
		repeat (10) @(negedge core_clk);
		chk({6'h00, busy, write_enable_latch}, 8'h00);
		prog(4'h2, 8'hFF, 8'h00, 1'b0);
		rdchk(4'h2, 8'hFE, {8'hFF, d1[2], d0[2]});
		wren();
		cmd(`OP_SEC_ERASE, {8'h00, 4'h1, 4'h3, 8'h00}, 9'h001);
		cmd(`OP_SEC_ERASE, 24'h011000, 9'h001);
		repeat (10) @(negedge core_clk);
		chk({6'h00, busy, write_enable_latch}, 8'h01);
		cmd(`OP_SEC_ERASE, sa(4'h1, 8'h00), 9'h001);
		cmd(`OP_SEC_READ, sa(4'h3, 8'hFF), 9'h001);
		bus(1'b0, `HR_DATA, 32'h00000000);
		chk(r[7:0], 8'hFF);
		chk({7'h00, busy}, 8'h01);
		settle();
		rdchk(4'h1, 8'hFE, 24'hFFFFFF);
		rdchk(4'h3, 8'hFE, {8'hFF, d1[3], d0[3]});
		conclude();
	end
endmodule : testbench
